// ---- inc/gle_pkg.sv ----
// register map, reset values and field positions of the gpio lookup-table expander
package gle_pkg;
    localparam logic [7:0] ADDR_DIR_B = 8'h00;
    localparam logic [7:0] ADDR_DIR_A = 8'h01;
    localparam logic [7:0] ADDR_DATA_B = 8'h02;
    localparam logic [7:0] ADDR_DATA_A = 8'h03;
    localparam logic [7:0] ADDR_PULLUP_B = 8'h04;
    localparam logic [7:0] ADDR_PULLUP_A = 8'h05;
    localparam logic [7:0] ADDR_MASK_B = 8'h06;
    localparam logic [7:0] ADDR_MASK_A = 8'h07;
    localparam logic [7:0] ADDR_SENSE_UP_B = 8'h08;
    localparam logic [7:0] ADDR_SENSE_LO_B = 8'h09;
    localparam logic [7:0] ADDR_SENSE_UP_A = 8'h0a;
    localparam logic [7:0] ADDR_SENSE_LO_A = 8'h0b;
    localparam logic [7:0] ADDR_FLAG_B = 8'h0c;
    localparam logic [7:0] ADDR_FLAG_A = 8'h0d;
    localparam logic [7:0] ADDR_LOGIC_MODE = 8'h0e;
    localparam logic [7:0] ADDR_UPPER_TABLE4 = 8'h2a;
    localparam logic [7:0] ADDR_LOWER_TABLE4 = 8'h2b;
    localparam logic [7:0] ADDR_ADVANCED = 8'had;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] RST_DATA = 8'hff;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [7:0] RST_SENSE = 8'h00;
    localparam logic [7:0] RST_FLAG = 8'h00;
    localparam logic [7:0] RST_LOGIC_MODE = 8'h00;
    localparam logic [7:0] RST_TABLE = 8'h00;
    localparam logic [7:0] RST_ADVANCED = 8'h00;
    localparam logic [7:0] ADV_WRITABLE = 8'h06;
    localparam int ADV_AUTOCLR_BIT = 2;
    localparam int ADV_BOOST_BIT = 1;
    localparam int LOGIC_LOWER_BIT = 0;
    localparam int LOGIC_UPPER_BIT = 1;
    localparam int UPPER_OUT_PIN = 12;
    localparam int LOWER_OUT_PIN = 4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // serial slave address, value arbitrary
    localparam logic [6:0] I2C_DEV_ADDR = 7'h20;
endpackage

// ---- src/gle_i2c_slave.sv ----
// two-wire serial slave giving byte register access with auto-increment
`timescale 1ns/100ps
`default_nettype none
module gle_i2c_slave
    import gle_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [7:0] reg_addr,
    output logic wr_stb,
    output logic [7:0] wr_data,
    output logic rd_stb,
    input wire logic [7:0] rd_data
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } gle_i2c_st_t;

    gle_i2c_st_t st_r;
    logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic rw_r, first_r;

    wire scl_rise = scl_s2_r & ~scl_d_r;
    wire scl_fall = ~scl_s2_r & scl_d_r;
    wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    wire stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
    wire byte_done = (cnt_r == BITS_PER_BYTE);

    // open drain: only the enable moves, the driven level is always low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
            {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
            sda_out <= 1'b0;
        end else begin
            {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_in, scl_s1_r, scl_s2_r};
            {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_in, sda_s1_r, sda_s2_r};
            sda_out <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            sda_oe <= 1'b0;
            reg_addr <= 8'h00;
            wr_stb <= 1'b0;
            wr_data <= 8'h00;
            rd_stb <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            if (start_det) begin
                st_r <= ST_ADDR;
                cnt_r <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                st_r <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (st_r == ST_ADDR || st_r == ST_WR) begin
                    sh_r <= {sh_r[6:0], sda_s2_r};
                    cnt_r <= cnt_r + 4'h1;
                end else if (st_r == ST_RD) begin
                    cnt_r <= cnt_r + 4'h1;
                end else if (st_r == ST_RD_ACK && sda_s2_r) begin
                    st_r <= ST_IDLE;
                end
            end else if (scl_fall) begin
                unique case (st_r)
                    ST_IDLE: begin
                    end
                    ST_ADDR: if (byte_done) begin
                        cnt_r <= 4'h0;
                        if (sh_r[7:1] == I2C_DEV_ADDR) begin
                            st_r <= ST_ADDR_ACK;
                            sda_oe <= 1'b1;
                            rw_r <= sh_r[0];
                        end else begin
                            st_r <= ST_IDLE;
                        end
                    end
                    ST_ADDR_ACK: if (rw_r) begin
                        st_r <= ST_RD;
                        sh_r <= rd_data;
                        sda_oe <= ~rd_data[7];
                        rd_stb <= 1'b1;
                    end else begin
                        st_r <= ST_WR;
                        sda_oe <= 1'b0;
                        first_r <= 1'b1;
                    end
                    ST_WR: if (byte_done) begin
                        cnt_r <= 4'h0;
                        st_r <= ST_WR_ACK;
                        sda_oe <= 1'b1;
                        if (first_r) begin
                            reg_addr <= sh_r;
                        end else begin
                            wr_stb <= 1'b1;
                            wr_data <= sh_r;
                        end
                    end
                    ST_WR_ACK: begin
                        st_r <= ST_WR;
                        sda_oe <= 1'b0;
                        first_r <= 1'b0;
                        if (!first_r) begin
                            reg_addr <= reg_addr + 8'h01;
                        end
                    end
                    ST_RD: if (byte_done) begin
                        cnt_r <= 4'h0;
                        st_r <= ST_RD_ACK;
                        sda_oe <= 1'b0;
                        reg_addr <= reg_addr + 8'h01;
                    end else begin
                        sh_r <= {sh_r[6:0], 1'b0};
                        sda_oe <= ~sh_r[6];
                    end
                    ST_RD_ACK: begin
                        st_r <= ST_RD;
                        sh_r <= rd_data;
                        sda_oe <= ~rd_data[7];
                        rd_stb <= 1'b1;
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- src/gle_gpio_top.sv ----
// sixteen-pin gpio expander core with two 3-to-1 lookup-table outputs and interrupt flags
// How it works
// - upper table mode drives pin 12 from upper fourth table indexed by pins 10..8.
// - lower table mode drives pin 4 from lower fourth table indexed by pins 2..0.
// - table bit n serves the input pattern whose binary value is n.
// - advanced bit 2 set: data register read clears flags and releases interrupt.
// - advanced bit 1 enables boost; resets to zero.
// - direction 0 makes an output; data 0 drives low, data 1 high.
// - direction 1 makes an input; pull-up bit 1 connects the pull-up.
// - mask 0 enables a pin's interrupt; sense pair 10 means falling edge.
// - writing ones to the flag register clears those flags; the interrupt releases once no flag is left.
`timescale 1ns/100ps
`default_nettype none
module gle_gpio_top
    import gle_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [15:0] io_in,
    output logic [15:0] io_out,
    output logic [15:0] io_oe,
    output logic [15:0] pullup_en,
    output logic boost_en,
    output logic irq_out_n
);
    logic wr_stb, rd_stb;
    logic [7:0] bus_addr, bus_wdata, bus_rdata;
    logic [15:0] dir_r, data_r, pullup_r, mask_r, flag_r, flag_nxt;
    logic [31:0] sense_r;
    logic [7:0] logic_mode_r, tbl_upper_r, tbl_lower_r, adv_r;
    logic [15:0] io_s1_r, io_s2_r, io_d_r;
    logic [15:0] io_out_r, io_oe_r, pullup_en_r;
    logic boost_en_r, irq_out_n_r;
    logic [15:0] evt, clr, out_nxt, oe_nxt;

    gle_i2c_slave u_slave (
        .clk(clk),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .reg_addr(bus_addr),
        .wr_stb(wr_stb),
        .wr_data(bus_wdata),
        .rd_stb(rd_stb),
        .rd_data(bus_rdata)
    );

    function automatic logic is_data_addr(input logic [7:0] a);
        return (a == ADDR_DATA_B) || (a == ADDR_DATA_A);
    endfunction

    // data reads return pin levels, so outputs read back what the wire carries
    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        case (a)
            ADDR_DIR_B: return dir_r[15:8];
            ADDR_DIR_A: return dir_r[7:0];
            ADDR_DATA_B: return io_s2_r[15:8];
            ADDR_DATA_A: return io_s2_r[7:0];
            ADDR_PULLUP_B: return pullup_r[15:8];
            ADDR_PULLUP_A: return pullup_r[7:0];
            ADDR_MASK_B: return mask_r[15:8];
            ADDR_MASK_A: return mask_r[7:0];
            ADDR_SENSE_UP_B: return sense_r[31:24];
            ADDR_SENSE_LO_B: return sense_r[23:16];
            ADDR_SENSE_UP_A: return sense_r[15:8];
            ADDR_SENSE_LO_A: return sense_r[7:0];
            ADDR_FLAG_B: return flag_r[15:8];
            ADDR_FLAG_A: return flag_r[7:0];
            ADDR_LOGIC_MODE: return logic_mode_r;
            ADDR_UPPER_TABLE4: return tbl_upper_r;
            ADDR_LOWER_TABLE4: return tbl_lower_r;
            ADDR_ADVANCED: return adv_r;
            default: return 8'h00;
        endcase
    endfunction

    // a process, not an assign: it must wake on every register the mux reads
    always_comb begin
        bus_rdata = rd_mux(bus_addr);
    end

    // per-pin edge select and mask
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_evt
            wire rise = io_s2_r[gi] & ~io_d_r[gi];
            wire fall = ~io_s2_r[gi] & io_d_r[gi];
            assign evt[gi] = ((sense_r[2*gi+1] & fall) | (sense_r[2*gi] & rise)) & ~mask_r[gi];
        end
    endgenerate

    wire autoclr = rd_stb && is_data_addr(bus_addr) && adv_r[ADV_AUTOCLR_BIT];
    wire wr_flag_b = wr_stb && (bus_addr == ADDR_FLAG_B);
    wire wr_flag_a = wr_stb && (bus_addr == ADDR_FLAG_A);
    assign clr = {(wr_flag_b ? bus_wdata : 8'h00), (wr_flag_a ? bus_wdata : 8'h00)}
        | {16{autoclr}};
    // a new edge in the clearing cycle survives
    assign flag_nxt = (flag_r & ~clr) | evt;

    wire upper_on = logic_mode_r[LOGIC_UPPER_BIT];
    wire lower_on = logic_mode_r[LOGIC_LOWER_BIT];
    wire tbl_upper_bit = tbl_upper_r[io_s2_r[10:8]];
    wire tbl_lower_bit = tbl_lower_r[io_s2_r[2:0]];
    assign out_nxt = {data_r[15:13], upper_on ? tbl_upper_bit : data_r[UPPER_OUT_PIN],
        data_r[11:5], lower_on ? tbl_lower_bit : data_r[LOWER_OUT_PIN], data_r[3:0]};
    assign oe_nxt = {~dir_r[15:13], upper_on | ~dir_r[UPPER_OUT_PIN],
        ~dir_r[11:5], lower_on | ~dir_r[LOWER_OUT_PIN], ~dir_r[3:0]};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_r <= {RST_DIR, RST_DIR};
            data_r <= {RST_DATA, RST_DATA};
            pullup_r <= {RST_PULLUP, RST_PULLUP};
            mask_r <= {RST_MASK, RST_MASK};
            sense_r <= {RST_SENSE, RST_SENSE, RST_SENSE, RST_SENSE};
            logic_mode_r <= RST_LOGIC_MODE;
            tbl_upper_r <= RST_TABLE;
            tbl_lower_r <= RST_TABLE;
            adv_r <= RST_ADVANCED;
        end else if (wr_stb) begin
            case (bus_addr)
                ADDR_DIR_B: dir_r[15:8] <= bus_wdata;
                ADDR_DIR_A: dir_r[7:0] <= bus_wdata;
                ADDR_DATA_B: data_r[15:8] <= bus_wdata;
                ADDR_DATA_A: data_r[7:0] <= bus_wdata;
                ADDR_PULLUP_B: pullup_r[15:8] <= bus_wdata;
                ADDR_PULLUP_A: pullup_r[7:0] <= bus_wdata;
                ADDR_MASK_B: mask_r[15:8] <= bus_wdata;
                ADDR_MASK_A: mask_r[7:0] <= bus_wdata;
                ADDR_SENSE_UP_B: sense_r[31:24] <= bus_wdata;
                ADDR_SENSE_LO_B: sense_r[23:16] <= bus_wdata;
                ADDR_SENSE_UP_A: sense_r[15:8] <= bus_wdata;
                ADDR_SENSE_LO_A: sense_r[7:0] <= bus_wdata;
                ADDR_LOGIC_MODE: logic_mode_r <= bus_wdata;
                ADDR_UPPER_TABLE4: tbl_upper_r <= bus_wdata;
                ADDR_LOWER_TABLE4: tbl_lower_r <= bus_wdata;
                // reserved bits held at zero even if the host slips
                ADDR_ADVANCED: adv_r <= bus_wdata & ADV_WRITABLE;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_s1_r <= 16'hffff;
            io_s2_r <= 16'hffff;
            io_d_r <= 16'hffff;
            flag_r <= {RST_FLAG, RST_FLAG};
            irq_out_n_r <= 1'b1;
            io_out_r <= {RST_DATA, RST_DATA};
            io_oe_r <= 16'h0000;
            pullup_en_r <= {RST_PULLUP, RST_PULLUP};
            boost_en_r <= 1'b0;
        end else begin
            io_s1_r <= io_in;
            io_s2_r <= io_s1_r;
            io_d_r <= io_s2_r;
            flag_r <= flag_nxt;
            irq_out_n_r <= ~(|flag_nxt);
            io_out_r <= out_nxt;
            io_oe_r <= oe_nxt;
            pullup_en_r <= pullup_r;
            boost_en_r <= adv_r[ADV_BOOST_BIT];
        end
    end

    assign io_out = io_out_r;
    assign io_oe = io_oe_r;
    assign pullup_en = pullup_en_r;
    assign boost_en = boost_en_r;
    assign irq_out_n = irq_out_n_r;

    property p_upper_table;
        @(posedge clk) disable iff (!rst_n)
        upper_on && !wr_stb ##1 $stable(io_s2_r[10:8]) |->
            io_oe_r[12] && (io_out_r[12] == tbl_upper_r[io_s2_r[10:8]]);
    endproperty
    a_upper_table: assert property (p_upper_table) else $error("pin 12 not from table");

    property p_lower_table;
        @(posedge clk) disable iff (!rst_n)
        lower_on && !wr_stb ##1 $stable(io_s2_r[2:0]) |->
            io_oe_r[4] && (io_out_r[4] == tbl_lower_r[io_s2_r[2:0]]);
    endproperty
    a_lower_table: assert property (p_lower_table) else $error("pin 4 not from table");

    property p_pattern_top;
        @(posedge clk) disable iff (!rst_n)
        lower_on && io_s2_r[2:0] == 3'h7 && !wr_stb |=>
            io_out_r[4] == tbl_lower_r[7];
    endproperty
    a_pattern_top: assert property (p_pattern_top) else $error("pattern 111 not bit 7");

    property p_autoclear;
        @(posedge clk) disable iff (!rst_n)
        rd_stb && is_data_addr(bus_addr) && adv_r[ADV_AUTOCLR_BIT] && evt == 16'h0000 |=>
            flag_r == 16'h0000 && irq_out_n;
    endproperty
    a_autoclear: assert property (p_autoclear) else $error("data read did not clear");

    property p_boost;
        @(posedge clk) disable iff (!rst_n)
        wr_stb && bus_addr == ADDR_ADVANCED |=> ##1 boost_en == $past(bus_wdata[1], 2);
    endproperty
    a_boost: assert property (p_boost) else $error("boost does not follow write");

    property p_output_drive;
        @(posedge clk) disable iff (!rst_n)
        !dir_r[0] && !wr_stb |=> io_oe[0] && io_out[0] == data_r[0];
    endproperty
    a_output_drive: assert property (p_output_drive) else $error("output pin not driven");

    property p_input_pullup;
        @(posedge clk) disable iff (!rst_n)
        dir_r[1] |=> !io_oe[1] && pullup_en[1] == $past(pullup_r[1]);
    endproperty
    a_input_pullup: assert property (p_input_pullup) else $error("input pin misbehaves");

    property p_falling_sets;
        @(posedge clk) disable iff (!rst_n)
        sense_r[1:0] == 2'h2 && !mask_r[0] && !io_s2_r[0] && io_d_r[0] |=>
            flag_r[0] && !irq_out_n;
    endproperty
    a_falling_sets: assert property (p_falling_sets) else $error("falling edge lost");

    property p_flag_clear;
        @(posedge clk) disable iff (!rst_n)
        wr_flag_a && bus_wdata == 8'hff && evt[7:0] == 8'h00 |=> flag_r[7:0] == 8'h00;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag write did not clear");

    property p_plain_gpio;
        @(posedge clk) disable iff (!rst_n)
        !lower_on && !wr_stb |=>
            io_out_r[4] == data_r[4] && io_oe_r[4] == !dir_r[4];
    endproperty
    a_plain_gpio: assert property (p_plain_gpio) else $error("pin 4 not plain gpio");
endmodule
`default_nettype wire

// ---- test/gle_host_model.sv ----
// serial bus master model standing in for the host controller
`timescale 1ns/100ps
`default_nettype none
module gle_host_model
    import gle_pkg::*;
(
    input wire logic clk,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low
);
    // bus idles released and pulled up
    initial begin
        scl_out = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // half periods of 8 clks keep well clear of the slave's 4-clk minimum
    task automatic put_bit(input logic b);
        sda_low <= ~b;
        tick(6);
        scl_out <= 1'b1;
        tick(8);
        scl_out <= 1'b0;
        tick(2);
    endtask
    // sampled mid high phase, long after the slave's 3-clk update
    task automatic get_bit(output logic b);
        sda_low <= 1'b0;
        tick(6);
        scl_out <= 1'b1;
        tick(4);
        b = sda_in;
        tick(4);
        scl_out <= 1'b0;
        tick(2);
    endtask
    // serves as first and repeated start alike
    task automatic start_cond();
        tick(1);
        sda_low <= 1'b0;
        tick(6);
        scl_out <= 1'b1;
        tick(8);
        sda_low <= 1'b1;
        tick(8);
        scl_out <= 1'b0;
        tick(2);
    endtask
    task automatic stop_cond();
        sda_low <= 1'b1;
        tick(6);
        scl_out <= 1'b1;
        tick(8);
        sda_low <= 1'b0;
        tick(8);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ok);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ok = ~b;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k1;
        logic k2;
        logic k3;
        start_cond();
        send_byte({I2C_DEV_ADDR, 1'b0}, k1);
        send_byte(a, k2);
        send_byte(d, k3);
        stop_cond();
        ok = k1 & k2 & k3;
    endtask
    // single byte read, ended by a nack so the slave lets go before stop
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic k1;
        logic k2;
        logic k3;
        start_cond();
        send_byte({I2C_DEV_ADDR, 1'b0}, k1);
        send_byte(a, k2);
        start_cond();
        send_byte({I2C_DEV_ADDR, 1'b1}, k3);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(1'b1);
        stop_cond();
        ok = k1 & k2 & k3;
    endtask
endmodule
`default_nettype wire

// ---- test/gpio_lut_output_and_irq_clear_bench.sv ----
// self-checking bench for lookup-table outputs, advanced settings and interrupt flags
`timescale 1ns/100ps
`default_nettype none
module gpio_lut_output_and_irq_clear_bench;
    import gle_pkg::*;
    // asymmetric patterns so a reversed bit order shows
    localparam logic [7:0] LO_TAB = 8'h1d;
    localparam logic [7:0] UP_TAB = 8'hb4;
    logic clk;
    logic rst_n;
    logic scl;
    logic host_low;
    logic sda;
    logic sda_out;
    logic sda_oe;
    logic [15:0] ext_r;
    logic [15:0] io_in;
    logic [15:0] io_out;
    logic [15:0] io_oe;
    logic [15:0] pullup_en;
    logic boost_en;
    logic irq_out_n;
    int errors;
    int n_tests;
    // open-drain data line with pull-up; pins resolved from every driver
    assign sda = (sda_oe ? sda_out : 1'b1) & ~host_low;
    assign io_in = (io_oe & io_out) | (~io_oe & (pullup_en | ext_r));
    gle_gpio_top DUT (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .pullup_en(pullup_en), .boost_en(boost_en), .irq_out_n(irq_out_n));
    gle_host_model host (.clk(clk), .sda_in(sda), .scl_out(scl), .sda_low(host_low));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic give_verdict();
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        host.reg_write(a, d, ok);
        chk1("write ack", 1'b1, ok);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic ok;
        logic [7:0] d;
        host.reg_read(a, d, ok);
        chk1("read ack", 1'b1, ok);
        chk8("read data", exp, d);
    endtask
    // pin change, then time for the 3-clk synchroniser and flag path
    task automatic pin(input int i, input logic v);
        @(posedge clk);
        ext_r[i] <= v;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        errors = 0;
        n_tests = 0;
        rst_n = 1'b0;
        ext_r = 16'hffff;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk16("io_oe", 16'h0000, io_oe);
        chk16("io_out", 16'hffff, io_out);
        chk16("pullup_en", 16'h0000, pullup_en);
        chk1("boost_en", 1'b0, boost_en);
        chk1("irq_out_n", 1'b1, irq_out_n);
        rd(ADDR_UPPER_TABLE4, RST_TABLE);
        rd(ADDR_LOWER_TABLE4, RST_TABLE);
        rd(ADDR_ADVANCED, RST_ADVANCED);
        rd(8'h50, 8'h00);
        // reserved advanced bits are only ever written as zero
        wr(ADDR_ADVANCED, 8'h02 & ADV_WRITABLE);
        chk1("boost_en", 1'b1, boost_en);
        rd(ADDR_ADVANCED, 8'h02);
        wr(ADDR_ADVANCED, 8'h00);
        chk1("boost_en", 1'b0, boost_en);
        wr(ADDR_DATA_A, 8'h5a);
        wr(ADDR_DIR_A, 8'h00);
        chk16("io_oe", 16'h00ff, io_oe);
        chk16("io_out", 16'hff5a, io_out);
        rd(ADDR_DATA_A, 8'h5a);
        wr(ADDR_DATA_A, 8'hef);
        chk16("io_out", 16'hffef, io_out);
        wr(ADDR_DIR_A, 8'hff);
        wr(ADDR_DATA_A, 8'hff);
        chk16("io_oe", 16'h0000, io_oe);
        wr(ADDR_PULLUP_B, 8'hff);
        chk16("pullup_en", 16'hff00, pullup_en);
        @(posedge clk);
        ext_r[15:8] <= 8'h00;
        rd(ADDR_DATA_B, 8'hff);
        wr(ADDR_PULLUP_B, 8'h00);
        rd(ADDR_DATA_B, 8'h00);
        @(posedge clk);
        ext_r <= 16'hffff;
        wr(ADDR_LOWER_TABLE4, LO_TAB);
        wr(ADDR_UPPER_TABLE4, UP_TAB);
        rd(ADDR_LOWER_TABLE4, LO_TAB);
        rd(ADDR_UPPER_TABLE4, UP_TAB);
        wr(ADDR_LOGIC_MODE, 8'h03);
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            ext_r[2:0] <= n[2:0];
            ext_r[10:8] <= 3'h7 - n[2:0];
            repeat (6) @(posedge clk);
            chk1("pin 4", LO_TAB[n], io_out[4]);
            chk1("pin 12", UP_TAB[7 - n], io_out[12]);
        end
        chk16("io_oe", 16'h1010, io_oe);
        wr(ADDR_LOGIC_MODE, 8'h01);
        chk16("io_oe", 16'h0010, io_oe);
        wr(ADDR_LOGIC_MODE, 8'h00);
        chk16("io_oe", 16'h0000, io_oe);
        chk16("io_out", 16'hffff, io_out);
        @(posedge clk);
        ext_r <= 16'hffff;
        wr(ADDR_MASK_A, 8'h00);
        wr(ADDR_SENSE_UP_A, 8'haa);
        wr(ADDR_SENSE_LO_A, 8'haa);
        wr(ADDR_SENSE_LO_B, 8'haa);
        pin(9, 1'b0);
        chk1("irq_out_n", 1'b1, irq_out_n);
        pin(9, 1'b1);
        pin(5, 1'b0);
        chk1("irq_out_n", 1'b0, irq_out_n);
        pin(5, 1'b1);
        rd(ADDR_FLAG_A, 8'h20);
        wr(ADDR_FLAG_A, 8'hff);
        chk1("irq_out_n", 1'b1, irq_out_n);
        pin(3, 1'b0);
        pin(0, 1'b0);
        wr(ADDR_FLAG_A, 8'h08);
        rd(ADDR_FLAG_A, 8'h01);
        chk1("irq_out_n", 1'b0, irq_out_n);
        wr(ADDR_FLAG_A, 8'hff);
        chk1("irq_out_n", 1'b1, irq_out_n);
        pin(3, 1'b1);
        pin(0, 1'b1);
        wr(ADDR_ADVANCED, 8'h04 & ADV_WRITABLE);
        pin(6, 1'b0);
        chk1("irq_out_n", 1'b0, irq_out_n);
        rd(ADDR_DATA_A, 8'hbf);
        chk1("irq_out_n", 1'b1, irq_out_n);
        rd(ADDR_FLAG_A, 8'h00);
        wr(ADDR_ADVANCED, 8'h00);
        pin(7, 1'b0);
        rd(ADDR_DATA_A, 8'h3f);
        chk1("irq_out_n", 1'b0, irq_out_n);
        rd(ADDR_FLAG_A, 8'h80);
        wr(ADDR_FLAG_A, 8'hff);
        chk1("irq_out_n", 1'b1, irq_out_n);
        // rising-edge sense on pins 7..4, so the other pair code is exercised too
        wr(ADDR_SENSE_UP_A, 8'h55);
        pin(7, 1'b1);
        rd(ADDR_FLAG_A, 8'h80);
        chk1("irq_out_n", 1'b0, irq_out_n);
        give_verdict();
    end
    // about 40 bus transfers of under 700 clks each fit well inside this span
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
